// ---- bench/pfp_protect_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

module pfp_protect_chk (
    input wire logic              clk,          // System clock
    input wire logic              reset,        // Sync reset, high
    input wire logic              special_pin,  // Special mode pin
    input wire pfp_pkg::pfp_bus_t bus,          // Register bus request
    input wire logic [7:0]        rdata,        // Read data
    input wire pfp_pkg::pfp_req_t cmd,          // Command request
    input wire logic              cmd_launch,   // Command passed on
    input wire logic              cmd_refused,  // Command refused
    input wire logic              viol_flag,    // Violation flag
    input wire logic              ready,        // Load finished
    input wire logic              cfg_rd_req,   // Config byte read
    input wire logic [17:0]       cfg_rd_addr,  // Config byte address
    input wire logic              cfg_rd_valid, // Config data valid
    input wire logic [7:0]        cfg_rd_data,  // Config byte
    input wire logic              cfg_rd_dbl    // Double-bit fault
);
    //------------------------------------------------------------
    // Properties
    //------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Software write of one to the violation bit
    wire logic clr = bus.wr && bus.addr == 4'h1 && bus.wdata[4];

    rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data outside its slot");
    cfg_addr_a: assert property (cfg_rd_addr == 18'h3FF0C)
        else $error("wrong configuration address");
    cmd_answer_a: assert property (
        cmd.valid |=> cmd_launch != cmd_refused)
        else $error("command not answered once");
    no_stray_a: assert property (
        (cmd_launch || cmd_refused) |-> $past(cmd.valid))
        else $error("answer without command");
    launch_ok_a: assert property (
        cmd_launch |-> $past(ready) && !$past(viol_flag))
        else $error("launch while blocked");
    viol_hold_a: assert property (viol_flag && !clr |=> viol_flag)
        else $error("violation flag dropped");
    viol_clear_a: assert property (
        viol_flag && clr && !cmd.valid |=> !viol_flag)
        else $error("violation flag not cleared");
    viol_cause_a: assert property ($rose(viol_flag) |-> cmd_refused)
        else $error("violation without refusal");
    flag_block_a: assert property (
        viol_flag && cmd.valid |=> cmd_refused)
        else $error("command passed while flagged");
    early_cmd_a: assert property (
        cmd.valid && !ready |=> cmd_refused && !viol_flag)
        else $error("command before load not refused");
    load_done_a: assert property (
        cfg_rd_req && cfg_rd_valid |-> ##[1:2] ready)
        else $error("load did not finish");
    req_hold_a: assert property (
        cfg_rd_req && !cfg_rd_valid |=> cfg_rd_req)
        else $error("config request dropped early");
endmodule

bind pfp_protect pfp_protect_chk chk_u (
    .clk(clk), .reset(reset), .special_pin(special_pin), .bus(bus),
    .rdata(rdata), .cmd(cmd), .cmd_launch(cmd_launch),
    .cmd_refused(cmd_refused), .viol_flag(viol_flag), .ready(ready),
    .cfg_rd_req(cfg_rd_req), .cfg_rd_addr(cfg_rd_addr),
    .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data),
    .cfg_rd_dbl(cfg_rd_dbl)
);

`default_nettype wire

// ---- bench/pfp_protect_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module pfp_protect_tb;
    //------------------------------------------------------------
    // Stimulus, expectations and instance
    //------------------------------------------------------------
    logic              clk;
    logic              reset;
    logic              special_pin;
    pfp_pkg::pfp_bus_t bus;
    pfp_pkg::pfp_req_t cmd;
    logic [7:0]        rdata;
    logic              cmd_launch;
    logic              cmd_refused;
    logic              viol_flag;
    logic              ready;
    logic              cfg_rd_req;
    logic              cfg_rd_valid;
    logic [7:0]        cfg_rd_data;
    logic              cfg_rd_dbl;
    logic [7:0]        got;
    logic [7:0]        prot_exp;
    logic              viol_exp;
    logic              spec;
    logic [31:0]       seed;
    logic [17:0]       hs;
    logic [17:0]       le;
    int                mismatches;
    int                n_compared;

    pfp_protect dut_u (
        .clk(clk), .reset(reset), .special_pin(special_pin), .bus(bus),
        .rdata(rdata), .cmd(cmd), .cmd_launch(cmd_launch),
        .cmd_refused(cmd_refused), .viol_flag(viol_flag), .ready(ready),
        .cfg_rd_req(cfg_rd_req), .cfg_rd_addr(), .cfg_rd_valid(cfg_rd_valid),
        .cfg_rd_data(cfg_rd_data), .cfg_rd_dbl(cfg_rd_dbl)
    );

    // Clock, 100 ns period
    always #50 clk = ~clk;

    //------------------------------------------------------------
    // Reference functions
    //------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] after_wr(input logic [7:0] cur,
                                            input logic [7:0] wd,
                                            input logic       sp);
        logic [63:0] tbl;
        logic [7:0]  nv;
        logic [7:0]  row;
        tbl = 64'hFF5A3C18080C0A0F;
        nv = wd;
        nv[6] = cur[6];
        if (sp)
            return nv;
        if (!cur[5])
            nv[4:3] = cur[4:3];
        if (!cur[2])
            nv[1:0] = cur[1:0];
        row = tbl[{cur[7], cur[5], cur[2]} * 8 +: 8];
        return row[{nv[7], nv[5], nv[2]}] ? nv : cur;
    endfunction

    function automatic logic is_prot(input logic [7:0]  p,
                                     input logic [17:0] a);
        logic in_rng;
        in_rng = (!p[5] && {1'b0, a} >= 19'h40000 - (19'h800 << p[4:3]))
              || (!p[2] && a >= 18'h38000
                  && a < 18'h38000 + (18'h400 << p[1:0]));
        return p[7] ? in_rng : !in_rng;
    endfunction

    //------------------------------------------------------------
    // Bus, command and reporting tasks
    //------------------------------------------------------------
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
    endtask

    task automatic regs;
        rd(pfp_pkg::OFS_PROT, got);
        check(got, prot_exp);
        rd(pfp_pkg::OFS_STATUS, got);
        check(got, {3'h0, viol_exp, 4'h0});
    endtask

    task automatic run_cmd(input logic [1:0] k, input logic [17:0] a);
        logic blk;
        logic refuse;
        blk = !prot_exp[7] || !prot_exp[5] || !prot_exp[2];
        refuse = viol_exp || (k == 2'h2 && blk)
                 || (k < 2'h2 && is_prot(prot_exp, a));
        @(posedge clk);
        cmd <= '{1'b1, pfp_pkg::pfp_cmd_t'(k), a};
        @(posedge clk);
        cmd <= '0;
        #1 viol_exp = viol_exp || refuse;
        check(cmd_refused, refuse);
        check(cmd_launch, !refuse);
        check(viol_flag, viol_exp);
    endtask

    task automatic boot(input logic [7:0] d, input logic dbl);
        reset <= 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        wr(pfp_pkg::OFS_PROT, 8'hFF);
        @(posedge clk);
        cmd <= '{1'b1, pfp_pkg::PFP_CMD_OTHER, 18'h3FFFF};
        @(posedge clk);
        cmd <= '0;
        #1 check(cmd_refused, 1'b1);
        rd(pfp_pkg::OFS_PROT, got);
        check(got, pfp_pkg::PROT_RESET);
        for (int n = 0; n < 20 && cfg_rd_req !== 1'b1; n++) #100;
        check(cfg_rd_req, 1'b1);
        @(posedge clk);
        cfg_rd_valid <= 1'b1;
        cfg_rd_data <= d;
        cfg_rd_dbl <= dbl;
        @(posedge clk);
        cfg_rd_valid <= 1'b0;
        cfg_rd_data <= ~d;
        cfg_rd_dbl <= 1'b0;
        #1 for (int n = 0; n < 20 && ready !== 1'b1; n++) #100;
        check(ready, 1'b1);
        prot_exp = dbl ? 8'h7F : d;
        viol_exp = 1'b0;
        regs();
    endtask

    task automatic set_mode(input logic v);
        @(posedge clk);
        special_pin <= v;
        repeat (5) @(posedge clk);
        spec = v;
    endtask

    //------------------------------------------------------------
    // Main sequence and watchdog
    //------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        special_pin = 1'b0;
        bus = '0;
        cmd = '0;
        cfg_rd_valid = 1'b0;
        cfg_rd_data = 8'h00;
        cfg_rd_dbl = 1'b0;
        spec = 1'b0;
        seed = 32'h5F7C;
        mismatches = 0;
        n_compared = 0;
        boot(8'hE5, 1'b1);
        boot(8'hFF, 1'b0);
        rd(4'hC, got);
        check(got, 8'h00);
        // Random writes, clears, commands, reloads and mode changes
        for (int i = 0; i < 300; i++)
        begin
            seed = xs(seed);
            if (seed[4:0] == 5'h00)
                boot(seed[15:8] | 8'h40, seed[5]);
            else if (seed[4:0] == 5'h01)
                set_mode(!spec);
            else if (seed[0])
            begin
                wr((seed[11:10] == 2'h3) ? 4'hC : pfp_pkg::OFS_PROT,
                   seed[23:16]);
                if (seed[11:10] != 2'h3)
                    prot_exp = after_wr(prot_exp, seed[23:16], spec);
                if (seed[12])
                begin
                    wr(pfp_pkg::OFS_STATUS, seed[31:24]);
                    viol_exp = viol_exp && !seed[28];
                end
                regs();
            end
            else
                run_cmd(seed[9:8], 18'h30000 + {2'h0, seed[31:16]});
        end
        // Range edges for every size code and both polarities
        set_mode(1'b1);
        for (int j = 0; j < 8; j++)
        begin
            wr(pfp_pkg::OFS_PROT, {j[2], 2'b10, j[1:0], 1'b0, j[1:0]});
            prot_exp = after_wr(prot_exp, {j[2], 2'b10, j[1:0], 1'b0, j[1:0]},
                                1'b1);
            regs();
            hs = 18'(19'h40000 - (19'h800 << j[1:0]));
            le = 18'h38000 + (18'h400 << j[1:0]);
            for (int m = 0; m < 4; m++)
            begin
                run_cmd({1'b0, m[0]}, (m[1] ? le : hs) - {17'h0, !m[0]});
                wr(pfp_pkg::OFS_STATUS, 8'h10);
                viol_exp = 1'b0;
            end
        end
        // Violation and clear in one cycle: the violation wins
        @(posedge clk);
        cmd <= '{1'b1, pfp_pkg::PFP_CMD_PROGRAM, pfp_pkg::ADDR_TOP};
        bus <= '{pfp_pkg::OFS_STATUS, 8'h10, 1'b1, 1'b0};
        @(posedge clk);
        cmd <= '0;
        bus <= '0;
        #1 check(viol_flag, is_prot(prot_exp, pfp_pkg::ADDR_TOP));
        check(cmd_refused, 1'b1);
        set_mode(1'b0);
        results();
    end

    // Watchdog for a hung run
    initial
    begin
        #2_000_000;
        mismatches++;
        results();
    end
endmodule

`default_nettype wire

// ---- logic/pfp_pkg.sv ----
`default_nettype none

package pfp_pkg;

    //------------------------------------------------------------
    // Register map
    //------------------------------------------------------------
    localparam logic [3:0] OFS_PROT   = 4'h0;  // Protection register
    localparam logic [3:0] OFS_STATUS = 4'h1;  // Flash status register

    //------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------
    localparam int BIT_POLARITY = 7;
    localparam int BIT_RSV_NV   = 6;
    localparam int BIT_HIGH_DIS = 5;
    localparam int BIT_HIGH_MSB = 4;
    localparam int BIT_HIGH_LSB = 3;
    localparam int BIT_LOW_DIS  = 2;
    localparam int BIT_LOW_MSB  = 1;
    localparam int BIT_LOW_LSB  = 0;
    localparam int BIT_VIOL     = 4;

    //------------------------------------------------------------
    // Values after reset and on a double-bit fault
    //------------------------------------------------------------
    localparam logic [7:0] PROT_RESET = 8'h7F;  // Fully protected
    localparam logic [7:0] PROT_FAULT = 8'h7F;  // Polarity clear, rest set
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    //------------------------------------------------------------
    // Global addresses
    //------------------------------------------------------------
    localparam logic [17:0] ADDR_CFG_BYTE = 18'h3FF0C;
    localparam logic [17:0] ADDR_TOP      = 18'h3FFFF;
    localparam logic [17:0] ADDR_LOW_BASE = 18'h38000;
    localparam logic [17:0] ADDR_HI_2K    = 18'h3F800;
    localparam logic [17:0] ADDR_HI_4K    = 18'h3F000;
    localparam logic [17:0] ADDR_HI_8K    = 18'h3E000;
    localparam logic [17:0] ADDR_HI_16K   = 18'h3C000;
    localparam logic [17:0] ADDR_LO_1K    = 18'h383FF;
    localparam logic [17:0] ADDR_LO_2K    = 18'h387FF;
    localparam logic [17:0] ADDR_LO_4K    = 18'h38FFF;
    localparam logic [17:0] ADDR_LO_8K    = 18'h39FFF;

    //------------------------------------------------------------
    // Types
    //------------------------------------------------------------
    typedef enum logic [1:0] {
        PFP_CMD_PROGRAM  = 2'h0,
        PFP_CMD_SECT_ERS = 2'h1,
        PFP_CMD_BLK_ERS  = 2'h2,
        PFP_CMD_OTHER    = 2'h3
    } pfp_cmd_t;

    typedef enum logic {
        PFP_LOAD = 1'b0,
        PFP_RUN  = 1'b1
    } pfp_state_t;

    typedef struct packed {
        logic        valid;
        pfp_cmd_t    kind;
        logic [17:0] addr;
    } pfp_req_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pfp_bus_t;

    typedef struct packed {
        pfp_state_t state;
        logic [7:0] prot;
        logic       viol;
        logic       launch;
        logic       refused;
        logic [7:0] rdata;
        logic       cfg_req;
        logic [2:0] mode_sync;
        logic       special;
    } pfp_regs_t;

endpackage

`default_nettype wire

// ---- logic/pfp_protect.sv ----
//
// Contract
// - Normal mode: a protection write may only grow the protected area.
// - Special mode: all non-reserved protection bits write freely.
// - At reset the register loads from the configuration byte in flash.
// - Double-bit fault on that load: polarity clear, all else set.
// - Program or erase into protected space is refused, violation set.
// - Block erase refused while any sector of the block is protected.
// - Polarity clear: enabled ranges are unprotected, rest protected.
// - Polarity set: enabled ranges alone are protected.
// - High disable bit 5: 0 enables top range, 1 disables it.
// - High size field writable only while high disable is set.
// - Low disable bit 2: 0 enables base range, 1 disables it.
// - Low size field writable only while low disable is set.
// - Both disabled: none protected if polarity 1, all if polarity 0.
// - High size codes give 2, 4, 8 or 16 Kbytes below top.
// - Low size codes give 1, 2, 4 or 8 Kbytes above base.
// - Normal mode: an invalid scenario write is dropped entirely.
// - Reading the register returns the scenario in force.
// - Valid transitions follow the fixed from-to table.
// - Violation flag blocks commands until software writes 1.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module pfp_protect #(
    parameter logic [17:0] PFLASH_BASE = 18'h30000  // Lowest flash address
) (
    input  wire logic              clk,          // System clock
    input  wire logic              reset,        // Sync reset, high
    input  wire logic              special_pin,  // Special mode pin
    input  wire pfp_pkg::pfp_bus_t bus,          // Register bus request
    output logic [7:0]             rdata,        // Read data, next cycle
    input  wire pfp_pkg::pfp_req_t cmd,          // Command request
    output logic                   cmd_launch,   // Command passed on
    output logic                   cmd_refused,  // Command refused
    output logic                   viol_flag,    // Violation flag
    output logic                   ready,        // Load finished
    output logic                   cfg_rd_req,   // Config byte read
    output logic [17:0]            cfg_rd_addr,  // Config byte address
    input  wire logic              cfg_rd_valid, // Config data valid
    input  wire logic [7:0]        cfg_rd_data,  // Config byte
    input  wire logic              cfg_rd_dbl    // Double-bit fault
);

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    pfp_pkg::pfp_regs_t r_reg;
    pfp_pkg::pfp_regs_t r_next;

    logic [2:0]  scen_cur;
    logic [2:0]  scen_new;
    logic [7:0]  cand;
    logic        trans_ok;
    logic        in_high;
    logic        in_low;
    logic        in_range;
    logic        in_flash;
    logic        addr_prot;
    logic        blk_prot;
    logic        target_prot;
    logic        is_pe;
    logic [17:0] hi_base;
    logic [17:0] lo_end;

    //------------------------------------------------------------
    // Scenario transition table
    //------------------------------------------------------------
    function automatic logic valid_trans(input logic [2:0] from,
                                         input logic [2:0] to);
        logic [7:0] allowed;
        allowed = 8'h00;
        unique case (from)
            3'h0: allowed = 8'h0F;  // 0 to 0-3
            3'h1: allowed = 8'h0A;  // 1 to 1,3
            3'h2: allowed = 8'h0C;  // 2 to 2,3
            3'h3: allowed = 8'h08;  // 3 to 3
            3'h4: allowed = 8'h18;  // 4 to 3,4
            3'h5: allowed = 8'h3C;  // 5 to 2-5
            3'h6: allowed = 8'h5A;  // 6 to 1,3,4,6
            3'h7: allowed = 8'hFF;  // 7 to any
        endcase
        return allowed[to];
    endfunction

    //------------------------------------------------------------
    // Range decode
    //------------------------------------------------------------
    always_comb
    begin
        unique case (r_reg.prot[pfp_pkg::BIT_HIGH_MSB:pfp_pkg::BIT_HIGH_LSB])
            2'h0: hi_base = pfp_pkg::ADDR_HI_2K;
            2'h1: hi_base = pfp_pkg::ADDR_HI_4K;
            2'h2: hi_base = pfp_pkg::ADDR_HI_8K;
            2'h3: hi_base = pfp_pkg::ADDR_HI_16K;
        endcase
        unique case (r_reg.prot[pfp_pkg::BIT_LOW_MSB:pfp_pkg::BIT_LOW_LSB])
            2'h0: lo_end = pfp_pkg::ADDR_LO_1K;
            2'h1: lo_end = pfp_pkg::ADDR_LO_2K;
            2'h2: lo_end = pfp_pkg::ADDR_LO_4K;
            2'h3: lo_end = pfp_pkg::ADDR_LO_8K;
        endcase
    end

    // Address check against the ranges in force
    always_comb
    begin
        in_flash = (cmd.addr >= PFLASH_BASE);
        in_high  = !r_reg.prot[pfp_pkg::BIT_HIGH_DIS]
                   && (cmd.addr >= hi_base)
                   && (cmd.addr <= pfp_pkg::ADDR_TOP);
        in_low   = !r_reg.prot[pfp_pkg::BIT_LOW_DIS]
                   && (cmd.addr >= pfp_pkg::ADDR_LOW_BASE)
                   && (cmd.addr <= lo_end);
        in_range = in_high || in_low;
        if (r_reg.prot[pfp_pkg::BIT_POLARITY])
        begin
            addr_prot = in_range;
        end
        else
        begin
            addr_prot = !in_range;
        end
        // Any enabled range or cleared polarity leaves a sector protected
        blk_prot = !r_reg.prot[pfp_pkg::BIT_POLARITY]
                   || !r_reg.prot[pfp_pkg::BIT_HIGH_DIS]
                   || !r_reg.prot[pfp_pkg::BIT_LOW_DIS];
        is_pe = (cmd.kind != pfp_pkg::PFP_CMD_OTHER);
        if (cmd.kind == pfp_pkg::PFP_CMD_BLK_ERS)
        begin
            target_prot = in_flash && blk_prot;
        end
        else
        begin
            target_prot = is_pe && in_flash && addr_prot;
        end
    end

    //------------------------------------------------------------
    // Write candidate and scenario check
    //------------------------------------------------------------
    always_comb
    begin
        cand = bus.wdata;
        // Reserved bit is not writable
        cand[pfp_pkg::BIT_RSV_NV] = r_reg.prot[pfp_pkg::BIT_RSV_NV];
        if (!r_reg.special)
        begin
            if (!r_reg.prot[pfp_pkg::BIT_HIGH_DIS])
            begin
                cand[pfp_pkg::BIT_HIGH_MSB:pfp_pkg::BIT_HIGH_LSB] =
                    r_reg.prot[pfp_pkg::BIT_HIGH_MSB:pfp_pkg::BIT_HIGH_LSB];
            end
            if (!r_reg.prot[pfp_pkg::BIT_LOW_DIS])
            begin
                cand[pfp_pkg::BIT_LOW_MSB:pfp_pkg::BIT_LOW_LSB] =
                    r_reg.prot[pfp_pkg::BIT_LOW_MSB:pfp_pkg::BIT_LOW_LSB];
            end
        end
        scen_cur = {r_reg.prot[pfp_pkg::BIT_POLARITY],
                    r_reg.prot[pfp_pkg::BIT_HIGH_DIS],
                    r_reg.prot[pfp_pkg::BIT_LOW_DIS]};
        scen_new = {cand[pfp_pkg::BIT_POLARITY],
                    cand[pfp_pkg::BIT_HIGH_DIS],
                    cand[pfp_pkg::BIT_LOW_DIS]};
        trans_ok = r_reg.special
                   || valid_trans(scen_cur, scen_new);
    end

    //------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------
    always_comb
    begin
        r_next         = r_reg;
        r_next.launch  = 1'b0;
        r_next.refused = 1'b0;
        r_next.rdata   = pfp_pkg::RDATA_IDLE;

        // Mode pin: three flops, change once the last two agree
        r_next.mode_sync = {r_reg.mode_sync[1:0], special_pin};
        if (r_reg.mode_sync[1] == r_reg.mode_sync[2])
        begin
            r_next.special = r_reg.mode_sync[2];
        end

        unique case (r_reg.state)
            pfp_pkg::PFP_LOAD:
            begin
                r_next.cfg_req = 1'b1;
                if (cfg_rd_valid)
                begin
                    r_next.cfg_req = 1'b0;
                    r_next.state   = pfp_pkg::PFP_RUN;
                    if (cfg_rd_dbl)
                    begin
                        r_next.prot = pfp_pkg::PROT_FAULT;
                    end
                    else
                    begin
                        r_next.prot = cfg_rd_data;
                    end
                end
                if (cmd.valid)
                begin
                    r_next.refused = 1'b1;
                end
            end
            pfp_pkg::PFP_RUN:
            begin
                // Protection register write
                if (bus.wr && bus.addr == pfp_pkg::OFS_PROT && trans_ok)
                begin
                    r_next.prot = cand;
                end
                // Command check; flag blocks any launch
                if (cmd.valid)
                begin
                    if (r_reg.viol)
                    begin
                        r_next.refused = 1'b1;
                    end
                    else if (target_prot)
                    begin
                        r_next.refused = 1'b1;
                        r_next.viol    = 1'b1;
                    end
                    else
                    begin
                        r_next.launch = 1'b1;
                    end
                end
                // Write 1 clears the flag; a new violation wins
                if (bus.wr && bus.addr == pfp_pkg::OFS_STATUS
                    && bus.wdata[pfp_pkg::BIT_VIOL]
                    && !(cmd.valid && !r_reg.viol && target_prot))
                begin
                    r_next.viol = 1'b0;
                end
            end
        endcase

        // Register reads, answered one cycle later
        if (bus.rd)
        begin
            if (bus.addr == pfp_pkg::OFS_PROT)
            begin
                r_next.rdata = r_reg.prot;
            end
            else if (bus.addr == pfp_pkg::OFS_STATUS)
            begin
                r_next.rdata[pfp_pkg::BIT_VIOL] = r_reg.viol;
            end
        end
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            r_reg.state     <= pfp_pkg::PFP_LOAD;
            r_reg.prot      <= pfp_pkg::PROT_RESET;
            r_reg.viol      <= 1'b0;
            r_reg.launch    <= 1'b0;
            r_reg.refused   <= 1'b0;
            r_reg.rdata     <= pfp_pkg::RDATA_IDLE;
            r_reg.cfg_req   <= 1'b0;
            r_reg.mode_sync <= 3'h0;
            r_reg.special   <= 1'b0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign rdata       = r_reg.rdata;
    assign cmd_launch  = r_reg.launch;
    assign cmd_refused = r_reg.refused;
    assign viol_flag   = r_reg.viol;
    assign ready       = (r_reg.state == pfp_pkg::PFP_RUN);
    assign cfg_rd_req  = r_reg.cfg_req;
    assign cfg_rd_addr = pfp_pkg::ADDR_CFG_BYTE;

endmodule

`default_nettype wire
